// ### core/rtdc_pkg.sv
// rtdc_pkg: constants and types for the rtd channel value path
// assumes resistance words in 0.1 ohm units and temperatures in 0.1 degree
`default_nettype none
package rtdc_pkg;
  // line fault thresholds, 0.1 ohm units
  localparam logic [15:0] BREAK_RES     = 16'h2710; // 1 kohm
  localparam logic [15:0] SHORT_RES     = 16'h0064; // 10 ohm
  // scaling defaults
  localparam logic [15:0] SCALE_START   = 16'h2710; // 10000 = 0 %
  localparam logic [15:0] SCALE_END     = 16'hC350; // 50000 = 100 %
  localparam int          WORD_MAX      = 65535;
  // status nibble layout
  localparam int          STAT_BITS     = 4;
  localparam int          STAT_FAULT    = 1;
  // platinum approximation: t = (r - r0) * gain / 64
  localparam int          PT_R0         = 1000;
  localparam int          PT_GAIN       = 166;
  localparam int          PT_SHIFT      = 6;
  localparam int          F_OFFSET      = 320; // 32.0 degrees
  // delivery period to the communication unit
  localparam int          CLK_MHZ       = 100;
  localparam int          DELIVER_US_X10 = 65; // 6.5 ms in 0.1 ms
  localparam int          DELIVER_CYC   = DELIVER_US_X10 * 100 * CLK_MHZ;
  // diagnostic record fields
  localparam logic [3:0]  CHAN_NUM      = 4'h1;
  localparam logic        CHAN_IS_OUT   = 1'b0;
  typedef enum logic [1:0] {
    RTDC_ERR_CUR  = 2'b00,
    RTDC_ERR_SUB  = 2'b01,
    RTDC_ERR_HOLD = 2'b10
  } rtdc_err_t;
  typedef enum logic [1:0] {
    RTDC_W2 = 2'b00,
    RTDC_W3 = 2'b01,
    RTDC_W4 = 2'b10
  } rtdc_wire_t;
  typedef enum logic [1:0] {
    RTDC_CAUSE_NONE  = 2'b00,
    RTDC_CAUSE_BREAK = 2'b01,
    RTDC_CAUSE_SHORT = 2'b10
  } rtdc_cause_t;
endpackage : rtdc_pkg
`default_nettype wire

// ### core/rtdc_channel.sv
// rtdc_channel: fault check, value policy, scaling and delivery fifo
// assumes measurement results arrive on ref_clk as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none

// fifo with registered output stage
module rtdc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  // drain side
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // pop into output stage when it is free or being taken
  assign push = in_valid && in_ready;
  assign pop  = (cnt_reg != '0) && (!out_valid || out_ready);

  // storage and pointers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr_reg] <= in_data;
        wr_ptr_reg      <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ready while not full, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_ready <= 1'b1;
    end else begin
      in_ready <= (cnt_reg + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
    end
  end

  // output stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : rtdc_fifo

// Summary of operation
// - break above 1 kohm, short below 10 ohm
// - fault check off suppresses both faults
// - value bad until N clean cycles pass
// - fault gives diagnostic and error mode policy
// - module fault sets module and global status
// - diagnostic names slot, channel, direction, cause
// - normal forwards field value, simulation forwards preset
// - current mode forwards present value unchanged
// - substitute mode outputs replacement during fault
// - hold mode keeps last pre-fault value
// - status bits only with default scaling
// - linear scale, start 0 %, end 100 %
// - 2/3/4 wire, 2-wire subtracts line resistance
// - linearise per sensor type selection
// - select 50 or 60 Hz rejection
// - fahrenheit unit only for platinum sensors
// - low four bits carry status nibble
// - status bit 1 is line fault
// - deliver word every 6.5 ms
module rtdc_channel #(
  parameter int DELAY_W   = 8,
  parameter int PERIOD    = rtdc_pkg::DELIVER_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // measurement from front end
  input  wire logic         meas_valid,
  input  wire logic [15:0]  meas_res,
  // configuration
  input  wire logic         cfg_line_fault_check,
  input  wire logic [DELAY_W-1:0] cfg_fault_delay,
  input  wire logic         cfg_sim_mode,
  input  wire logic [1:0]   cfg_err_mode,
  input  wire logic         cfg_status_en,
  input  wire logic [15:0]  cfg_scale_start,
  input  wire logic [15:0]  cfg_scale_end,
  input  wire logic [1:0]   cfg_wiring,
  input  wire logic [15:0]  cfg_line_res,
  input  wire logic         cfg_sensor_pt,
  input  wire logic         cfg_mains_60hz,
  input  wire logic         cfg_unit_f,
  input  wire logic signed [15:0] cfg_range_lo,
  input  wire logic signed [15:0] cfg_range_hi,
  input  wire logic [15:0]  cfg_sim_value,
  input  wire logic [15:0]  cfg_subst_value,
  input  wire logic [4:0]   cfg_slot,
  input  wire logic         cfg_diag_en,
  // fault and status
  output var  logic         fault_break_reg,
  output var  logic         fault_short_reg,
  output var  logic         meas_bad_reg,
  output var  logic         module_err_reg,
  output var  logic         global_err_reg,
  output var  logic         rej_60hz_reg,
  // diagnostic record
  output var  logic         diag_valid_reg,
  output var  logic [4:0]   diag_slot_reg,
  output var  logic [3:0]   diag_chan_reg,
  output var  logic         diag_is_out_reg,
  output var  logic [1:0]   diag_cause_reg,
  // value stream to communication unit
  output var  logic         out_valid,
  output var  logic [15:0]  out_data,
  input  wire logic         out_ready
);
  localparam int TW = $clog2(PERIOD);
  logic               brk_now;
  logic               sht_now;
  logic               fault_now;
  logic [DELAY_W-1:0] good_cnt_reg;
  logic [15:0]        meas_word_reg;
  logic [15:0]        last_valid_reg;
  logic [15:0]        src_word;
  logic [15:0]        sel_word;
  logic [15:0]        word_next;
  logic [15:0]        value_word_reg;
  logic [15:0]        scaled;
  logic               status_ok;
  logic [TW-1:0]      tick_cnt_reg;
  logic               pend_reg;
  logic [15:0]        pend_data_reg;
  logic               fifo_ready;

  // loop resistance compare
  assign brk_now   = cfg_line_fault_check && (meas_res > rtdc_pkg::BREAK_RES);
  assign sht_now   = cfg_line_fault_check && (meas_res < rtdc_pkg::SHORT_RES);
  assign fault_now = brk_now || sht_now;

  // fault cause flags, cleared when checking is off
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cfg_line_fault_check) begin
      fault_break_reg <= 1'b0;
      fault_short_reg <= 1'b0;
    end else if (meas_valid) begin
      fault_break_reg <= brk_now;
      fault_short_reg <= sht_now;
    end
  end

  // bad flag with clean-cycle clear delay
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !cfg_line_fault_check) begin
      meas_bad_reg <= 1'b0;
      good_cnt_reg <= '0;
    end else if (meas_valid) begin
      if (fault_now) begin
        meas_bad_reg <= 1'b1;
        good_cnt_reg <= '0;
      end else if (meas_bad_reg) begin
        if (DELAY_W'(good_cnt_reg + 1'b1) >= cfg_fault_delay) begin
          meas_bad_reg <= 1'b0;
          good_cnt_reg <= '0;
        end else begin
          good_cnt_reg <= good_cnt_reg + 1'b1;
        end
      end
    end
  end

  // diagnostic record on a new fault
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      diag_valid_reg  <= 1'b0;
      diag_slot_reg   <= '0;
      diag_chan_reg   <= '0;
      diag_is_out_reg <= 1'b0;
      diag_cause_reg  <= rtdc_pkg::RTDC_CAUSE_NONE;
    end else begin
      diag_valid_reg <= meas_valid && fault_now && !fault_break_reg && !fault_short_reg;
      if (meas_valid && fault_now) begin
        diag_slot_reg   <= cfg_slot;
        diag_chan_reg   <= rtdc_pkg::CHAN_NUM;
        diag_is_out_reg <= rtdc_pkg::CHAN_IS_OUT;
        diag_cause_reg  <= brk_now ? rtdc_pkg::RTDC_CAUSE_BREAK : rtdc_pkg::RTDC_CAUSE_SHORT;
      end
    end
  end

  // module and global status, mains filter select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      module_err_reg <= 1'b0;
      global_err_reg <= 1'b0;
      rej_60hz_reg   <= 1'b0;
    end else begin
      module_err_reg <= cfg_diag_en && meas_bad_reg;
      global_err_reg <= cfg_diag_en && meas_bad_reg;
      rej_60hz_reg   <= cfg_mains_60hz;
    end
  end

  // compensation, linearisation and scaling, all signed so a negative result clamps to 0
  always_comb begin
    logic signed [31:0] rc;
    logic signed [31:0] x;
    logic signed [31:0] den;
    logic signed [47:0] w;
    w   = '0;
    den = (cfg_range_hi > cfg_range_lo) ? 32'(cfg_range_hi) - 32'(cfg_range_lo) : 32'sd1;
    rc  = 32'(meas_res);
    if (cfg_wiring == rtdc_pkg::RTDC_W2) begin
      rc = (meas_res > cfg_line_res) ? 32'(meas_res - cfg_line_res) : '0;
    end
    x = rc;
    if (cfg_sensor_pt) begin
      x = ((rc - rtdc_pkg::PT_R0) * rtdc_pkg::PT_GAIN) >>> rtdc_pkg::PT_SHIFT;
      if (cfg_unit_f) begin
        x = (x * 9) / 5 + rtdc_pkg::F_OFFSET;
      end
    end
    w = $signed(48'(cfg_scale_start)) + 48'(x - 32'(cfg_range_lo))
        * $signed(48'(cfg_scale_end) - 48'(cfg_scale_start)) / 48'(den);
    scaled = (w < 0) ? '0 : (w > rtdc_pkg::WORD_MAX) ? 16'hFFFF : w[15:0];
  end

  // latest scaled field value
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meas_word_reg <= '0;
    end else if (meas_valid) begin
      meas_word_reg <= scaled;
    end
  end

  // source and error mode selection
  assign src_word = cfg_sim_mode ? cfg_sim_value : meas_word_reg;
  always_comb begin
    sel_word = src_word;
    if (meas_bad_reg) begin
      unique case (cfg_err_mode)
        rtdc_pkg::RTDC_ERR_SUB:  sel_word = cfg_subst_value;
        rtdc_pkg::RTDC_ERR_HOLD: sel_word = last_valid_reg;
        default:                 sel_word = src_word;
      endcase
    end
  end

  // last valid value frozen while bad
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_valid_reg <= '0;
    end else if (!meas_bad_reg) begin
      last_valid_reg <= src_word;
    end
  end

  // status nibble insertion
  assign status_ok = cfg_status_en && (cfg_scale_start == rtdc_pkg::SCALE_START)
                     && (cfg_scale_end == rtdc_pkg::SCALE_END);
  assign word_next = status_ok ? {sel_word[15:rtdc_pkg::STAT_BITS], 2'b00, meas_bad_reg, 1'b0}
                               : sel_word;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      value_word_reg <= '0;
    end else begin
      value_word_reg <= word_next;
    end
  end
  // fixed delivery period
  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick_cnt_reg == TW'(PERIOD - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // pending word waits for fifo room
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= '0;
    end else if (tick_cnt_reg == TW'(PERIOD - 1)) begin
      pend_reg      <= 1'b1;
      pend_data_reg <= value_word_reg;
    end else if (fifo_ready) begin
      pend_reg <= 1'b0;
    end
  end

  rtdc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (pend_reg),
    .in_data   (pend_data_reg),
    .in_ready  (fifo_ready),
    .out_valid (out_valid),
    .out_data  (out_data),
    .out_ready (out_ready)
  );
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  break_flag_a: assert property (meas_valid && cfg_line_fault_check && meas_res > 16'h2710
    ##1 cfg_line_fault_check |-> fault_break_reg) else $error("break not flagged");
  short_flag_a: assert property (meas_valid && cfg_line_fault_check && meas_res < 16'h0064
    ##1 cfg_line_fault_check |-> fault_short_reg) else $error("short not flagged");
  check_off_a: assert property (!cfg_line_fault_check |=> !meas_bad_reg && !fault_break_reg)
    else $error("fault with check off");
  clear_delay_a: assert property (meas_bad_reg && cfg_line_fault_check && meas_valid
    && !fault_now && DELAY_W'(good_cnt_reg + 1'b1) < cfg_fault_delay |=> meas_bad_reg)
    else $error("bad cleared early");
  count_restart_a: assert property (meas_valid && fault_now |=> good_cnt_reg == '0
    && meas_bad_reg) else $error("count not restarted");
  diag_rec_a: assert property (meas_valid && brk_now && !fault_break_reg && !fault_short_reg
    |=> diag_valid_reg && diag_cause_reg == 2'b01 && diag_slot_reg == $past(cfg_slot))
    else $error("diagnostic missing");
  mod_status_a: assert property (cfg_diag_en && meas_bad_reg ##1 cfg_diag_en
    |-> module_err_reg && global_err_reg) else $error("status not set");
  sim_value_a: assert property (cfg_sim_mode && !meas_bad_reg && !status_ok
    |=> value_word_reg == $past(cfg_sim_value)) else $error("sim value lost");
  subst_value_a: assert property (meas_bad_reg && cfg_err_mode == 2'b01 && !status_ok
    |=> value_word_reg == $past(cfg_subst_value)) else $error("substitute lost");
  hold_value_a: assert property (meas_bad_reg ##1 meas_bad_reg |-> $stable(last_valid_reg))
    else $error("hold value moved");
  status_nib_a: assert property (status_ok |=> value_word_reg[1] == $past(meas_bad_reg)
    && value_word_reg[0] == 1'b0 && value_word_reg[3:2] == 2'b00)
    else $error("status nibble wrong");
  period_a: assert property (tick_cnt_reg == TW'(PERIOD - 1) |=> pend_reg
    && pend_data_reg == $past(value_word_reg)) else $error("delivery missed");
  fault_onset_c: cover property (meas_valid && fault_now ##1 diag_valid_reg);
  fault_clear_c: cover property (meas_bad_reg ##1 !meas_bad_reg);
  fifo_stall_c:  cover property (pend_reg && !fifo_ready);
  deliver_c:     cover property (out_valid && out_ready);
endmodule : rtdc_channel

`default_nettype wire

// ### test/rtdc_comm_model.sv
// rtdc_comm_model: communication unit side of the channel value stream
// assumes one clock domain, words offered by the channel with valid/ready
`timescale 1ns/100ps
`default_nettype none
module rtdc_comm_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // value stream from the channel
  input  wire logic        out_valid,
  input  wire logic [15:0] out_data,
  output var  logic        out_ready,
  // bench control and observation
  input  wire logic        stall,
  output var  logic [15:0] last_word,
  output var  int          word_count,
  output var  int          gap
);
  int since;

  // ready drops while the bench asks for a stall
  always_comb out_ready = !stall;

  // take accepted words and time their spacing in clocks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_word  <= 16'h0000;
      word_count <= 0;
      gap        <= 0;
      since      <= 1;
    end else if (out_valid && out_ready) begin
      last_word  <= out_data;
      word_count <= word_count + 1;
      gap        <= since;
      since      <= 1;
    end else begin
      since <= since + 1;
    end
  end
endmodule : rtdc_comm_model
`default_nettype wire

// ### test/rtdc_channel_tb.sv
// rtdc_channel_tb: self-checking bench for the rtd channel value path
// assumes the comm unit model drains words and a short delivery period
`timescale 1ns/100ps
`default_nettype none
module rtdc_channel_tb;
  localparam int PER = 50;
  typedef struct packed {
    logic [15:0] res;
    logic [7:0]  md;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] w;
    logic [1:0]  bs;
  } rtdc_row_t;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               meas_valid = 1'b0;
  logic [15:0]        meas_res = 16'h0000;
  logic               cfg_line_fault_check, cfg_sim_mode, cfg_sensor_pt, cfg_unit_f;
  logic               cfg_status_en = 1'b0, cfg_mains_60hz = 1'b0, cfg_diag_en = 1'b0;
  logic [7:0]         cfg_fault_delay = 8'h00;
  logic [1:0]         cfg_err_mode, cfg_wiring;
  logic [15:0]        cfg_scale_start = rtdc_pkg::SCALE_START;
  logic [15:0]        cfg_scale_end = rtdc_pkg::SCALE_END;
  logic [15:0]        cfg_line_res = 16'h0064, cfg_sim_value = 16'h1234;
  logic [15:0]        cfg_subst_value = 16'hABCD;
  logic signed [15:0] cfg_range_lo, cfg_range_hi;
  logic [4:0]         cfg_slot = 5'h13;
  logic               stall = 1'b0;
  logic               fault_break_reg, fault_short_reg, meas_bad_reg, module_err_reg;
  logic               global_err_reg, rej_60hz_reg, diag_valid_reg, diag_is_out_reg;
  logic               out_valid, out_ready;
  logic [4:0]         diag_slot_reg;
  logic [3:0]         diag_chan_reg;
  logic [1:0]         diag_cause_reg;
  logic [15:0]        out_data, last_word;
  int                 word_count, gap, c0;
  int                 err_count = 0;
  int                 n_compared = 0;
  // md = {check, sim, err mode, wiring, platinum, fahrenheit}
  rtdc_row_t rows [16] = '{
    '{16'h07D0, 8'h88, 16'h0000, 16'h0FA0, 16'h7530, 2'h0},
    '{16'h2710, 8'h88, 16'h0000, 16'h0FA0, 16'hFFFF, 2'h0},
    '{16'h2EE0, 8'h88, 16'h0000, 16'h0FA0, 16'hFFFF, 2'h2},
    '{16'h0064, 8'h88, 16'h0000, 16'h0FA0, 16'h2AF8, 2'h0},
    '{16'h0032, 8'h88, 16'h0000, 16'h0FA0, 16'h2904, 2'h1},
    '{16'h2EE0, 8'h08, 16'h0000, 16'h0FA0, 16'hFFFF, 2'h0},
    '{16'h07D0, 8'h80, 16'h0000, 16'h0FA0, 16'h7148, 2'h0},
    '{16'h07D0, 8'h84, 16'h0000, 16'h0FA0, 16'h7530, 2'h0},
    '{16'h07D0, 8'h89, 16'h0000, 16'h0FA0, 16'h7530, 2'h0},
    '{16'h0568, 8'h8A, 16'h0000, 16'h03E8, 16'hC2B0, 2'h0},
    '{16'h0568, 8'h8B, 16'h0140, 16'h0848, 16'hC29E, 2'h0},
    '{16'h07D0, 8'hC8, 16'h0000, 16'h0FA0, 16'h1234, 2'h0},
    '{16'h2EE0, 8'hC8, 16'h0000, 16'h0FA0, 16'h1234, 2'h2},
    '{16'h2EE0, 8'h98, 16'h0000, 16'h0FA0, 16'hABCD, 2'h2},
    '{16'h0BB8, 8'hA8, 16'h0000, 16'h0FA0, 16'h9C40, 2'h0},
    '{16'h2EE0, 8'hA8, 16'h0000, 16'h0FA0, 16'h9C40, 2'h2}};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  rtdc_channel #(.DELAY_W(8), .PERIOD(PER), .FIFO_DEPTH(8)) uut (
    .ref_clk, .rst_n, .meas_valid, .meas_res, .cfg_line_fault_check, .cfg_fault_delay,
    .cfg_sim_mode, .cfg_err_mode, .cfg_status_en, .cfg_scale_start, .cfg_scale_end,
    .cfg_wiring, .cfg_line_res, .cfg_sensor_pt, .cfg_mains_60hz, .cfg_unit_f,
    .cfg_range_lo, .cfg_range_hi, .cfg_sim_value, .cfg_subst_value, .cfg_slot,
    .cfg_diag_en, .fault_break_reg, .fault_short_reg, .meas_bad_reg, .module_err_reg,
    .global_err_reg, .rej_60hz_reg, .diag_valid_reg, .diag_slot_reg, .diag_chan_reg,
    .diag_is_out_reg, .diag_cause_reg, .out_valid, .out_data, .out_ready);

  rtdc_comm_model peer (
    .ref_clk, .rst_n, .out_valid, .out_data, .out_ready, .stall, .last_word,
    .word_count, .gap);

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one measuring cycle result, one clock wide
  task automatic meas(input logic [15:0] r);
    @(posedge ref_clk) #1;
    meas_valid = 1'b1;
    meas_res = r;
    @(posedge ref_clk) #1;
    meas_valid = 0;
  endtask : meas

  // wait for n more delivered words, bounded
  task automatic wait_words(input int n);
    c0 = word_count;
    for (int k = 0; k < 4 * n * PER && word_count < c0 + n; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(16'(word_count >= c0 + n), 16'h0001);
  endtask : wait_words

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // watchdog well past the expected run length
  initial begin
    #300000;
    err_count++;
    final_report();
  end

  initial begin
    {cfg_line_fault_check, cfg_sim_mode, cfg_err_mode, cfg_wiring, cfg_sensor_pt,
     cfg_unit_f} = 8'h88;
    cfg_range_lo = 16'sh0000;
    cfg_range_hi = 16'sh0FA0;
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // table of ordinary cases
    foreach (rows[i]) begin
      {cfg_line_fault_check, cfg_sim_mode, cfg_err_mode, cfg_wiring, cfg_sensor_pt,
       cfg_unit_f} = rows[i].md;
      cfg_range_lo = rows[i].lo;
      cfg_range_hi = rows[i].hi;
      meas(rows[i].res);
      chk(16'({fault_break_reg, fault_short_reg}), 16'(rows[i].bs));
      wait_words(2);
      chk(last_word, rows[i].w);
    end
    chk(16'(gap), 16'(PER));
    // diagnostic record for break then short
    cfg_err_mode = 2'h0;
    cfg_diag_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      meas(16'h07D0);
      @(posedge ref_clk) #1;
      chk(16'(module_err_reg), 16'h0000);
      meas(i ? 16'h0032 : 16'h2EE0);
      chk(16'({diag_valid_reg, diag_slot_reg, diag_chan_reg, diag_is_out_reg,
               diag_cause_reg}), 16'({1'b1, 5'h13, 4'h1, 1'b0, 2'(i + 1)}));
      @(posedge ref_clk) #1;
      chk(16'({module_err_reg, global_err_reg, diag_valid_reg}), 16'h0006);
    end
    // clear delay with a fault in mid-count, status nibble on
    cfg_fault_delay = 8'h03;
    cfg_status_en = 1'b1;
    for (int i = 0; i < 7; i++) begin
      meas((i == 0 || i == 3) ? 16'h2EE0 : 16'h07D0);
      chk(16'(meas_bad_reg), 16'(i < 6));
      if (i == 5) begin
        wait_words(2);
        chk(last_word, 16'h7532);
      end
    end
    wait_words(2);
    chk(last_word, 16'h7530);
    cfg_scale_start = 16'h0000;
    meas(16'h07D0);
    wait_words(2);
    chk(last_word, 16'h61A8);
    cfg_scale_start = rtdc_pkg::SCALE_START;
    // mains filter selection both ways
    for (int i = 0; i < 2; i++) begin
      cfg_mains_60hz = (i == 0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(16'(rej_60hz_reg), 16'(i == 0));
    end
    // far side stalls until the fifo refuses, then drains; aligned to a delivery
    wait_words(1);
    stall = 1'b1;
    c0 = word_count;
    repeat (12 * PER) @(posedge ref_clk);
    #1;
    chk(16'({out_valid, 15'(word_count - c0)}), 16'h8000);
    stall = 1'b0;
    repeat (PER / 2) @(posedge ref_clk);
    #1;
    chk(16'(word_count - c0), 16'h000A);
    // reset in mid-run clears flags and stream
    meas(16'h2EE0);
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'({fault_break_reg, meas_bad_reg, out_valid, diag_valid_reg}), 16'h0000);
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(16'({meas_bad_reg, module_err_reg, out_valid, diag_valid_reg}), 16'h0000);
    meas(16'h2EE0);
    chk(16'({fault_break_reg, diag_valid_reg}), 16'h0003);
    final_report();
  end
endmodule : rtdc_channel_tb
`default_nettype wire
